// ### dv/cmc_mode_ctrl_asserts.sv
`timescale 1ns/1ps

module cmc_mode_ctrl_asserts #(
	parameter int IDLE_BITS = 11
) (
	// watched ports
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic        avs_waitrequest_out,
	input wire logic        bit_tick_in,
	input wire logic        rx_bit_in,
	input wire logic        tx_busy_in,
	input wire logic        tx_all_aborted_in,
	input wire logic        rx_msg_done_in,
	input wire logic        cpu_idle_in,
	input wire logic        module_halt_out,
	input wire logic        abort_all_transmits_out,
	input wire logic        capture_event_out,
	input wire logic        register_view_select_out,
	input wire logic [2:0]  current_operating_state_out,
	input wire logic        tx_enable_out,
	input wire logic        rx_enable_out,
	input wire logic        send_ack_errors_out,
	input wire logic        loopback_out,
	input wire logic        listen_all_out,
	input wire logic        pins_to_can_out
);
	logic [7:0] rec_cnt;
	wire logic  wr_ok = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0;
	wire logic  ab_wr = wr_ok && avs_byteenable_in[1] && avs_writedata_in[12];
	wire logic [5:0] outs = {tx_enable_out, rx_enable_out, send_ack_errors_out,
		loopback_out, listen_all_out, pins_to_can_out};
	wire logic [2:0] cur = current_operating_state_out;

	// saturates so a long quiet bus never wraps back to busy
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || (bit_tick_in && !rx_bit_in))
			rec_cnt <= 8'h00;
		else if (bit_tick_in && rec_cnt != 8'hff)
			rec_cnt <= rec_cnt + 8'h01;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_halt_needs_idle: assert property (module_halt_out |-> $past(cpu_idle_in))
		else $error("halt without cpu idle");
	a_abort_set_write: assert property
		($rose(abort_all_transmits_out) |-> $past(ab_wr))
		else $error("abort set without write");
	a_abort_set_wins: assert property (ab_wr |=> abort_all_transmits_out)
		else $error("abort write lost");
	a_abort_clears: assert property
		(abort_all_transmits_out && tx_all_aborted_in && !ab_wr |=> !abort_all_transmits_out)
		else $error("abort not cleared");
	a_no_rsvd_state: assert property (cur != 3'h5 && cur != 3'h6)
		else $error("reserved state adopted");
	a_change_waits_idle: assert property
		($changed(cur) && $past(cur) != 3'h1 && $past(cur) != 3'h4
		|-> $past(rec_cnt) >= IDLE_BITS || $past(rec_cnt, 2) >= IDLE_BITS)
		else $error("state left before bus idle");
	a_config_not_busy: assert property
		($changed(cur) && cur == 3'h4 |-> !$past(tx_busy_in))
		else $error("configuration entered while sending");
	a_normal_outs: assert property ($past(cur) == 3'h0 |-> outs == 6'h39)
		else $error("normal outputs wrong");
	a_loopback_outs: assert property ($past(cur) == 3'h2 |-> outs == 6'h34)
		else $error("loopback outputs wrong");
	a_listen_all_outs: assert property ($past(cur) == 3'h7 |-> outs == 6'h13)
		else $error("listen-all outputs wrong");
	a_capture_cause: assert property (capture_event_out |-> $past(rx_msg_done_in))
		else $error("capture without message");
	a_view_by_write: assert property
		($changed(register_view_select_out) |-> $past(wr_ok && avs_byteenable_in[0])
		&& $past(avs_writedata_in[0]) == register_view_select_out)
		else $error("view select changed without write");
	a_wait_one_cycle: assert property
		((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("access not answered");
endmodule : cmc_mode_ctrl_asserts

bind cmc_mode_ctrl cmc_mode_ctrl_asserts #(.IDLE_BITS(IDLE_BITS)) u_cmc_mode_ctrl_asserts (.*);

// ### dv/cmc_mode_ctrl_tb.sv
`timescale 1ns/1ps

module cmc_mode_ctrl_tb;
	localparam int IB = 3;
	typedef struct packed {
		logic [2:0] code;
		logic [5:0] outs;
	} cmc_row_t;
	localparam cmc_row_t ROWS [6] = '{'{3'h0, 6'h39}, '{3'h2, 6'h34}, '{3'h3, 6'h11},
		'{3'h7, 6'h13}, '{3'h1, 6'h00}, '{3'h4, 6'h00}};
	logic        clk_in, sys_rst_in, avs_read_in, avs_write_in, bit_tick_in, rx_bit_in;
	logic        tx_all_aborted_in, rx_msg_done_in, cpu_idle_in, tx_busy_in;
	logic [3:0]  avs_address_in, avs_byteenable_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rd;
	logic        avs_waitrequest_out, module_halt_out, abort_all_transmits_out;
	logic        capture_event_out, register_view_select_out, tx_enable_out, rx_enable_out;
	logic        send_ack_errors_out, loopback_out, listen_all_out, pins_to_can_out;
	logic [2:0]  current_operating_state_out;
	wire logic [5:0] outs = {tx_enable_out, rx_enable_out, send_ack_errors_out,
		loopback_out, listen_all_out, pins_to_can_out};
	int          n_mismatch, checks, cycles;

	cmc_mode_ctrl #(.IDLE_BITS(IB)) u_cmc_mode_ctrl (.*);

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus

	// between ticks the line shows the inverse, so stale values never count
	task automatic ticks(input int n, input logic v);
		repeat (n)
		begin
			@(posedge clk_in);
			bit_tick_in <= 1'b1;
			rx_bit_in <= v;
			@(posedge clk_in);
			bit_tick_in <= 1'b0;
			rx_bit_in <= ~v;
		end
	endtask : ticks

	task automatic pulse(input logic rx);
		@(posedge clk_in);
		rx_msg_done_in <= rx;
		tx_all_aborted_in <= !rx;
		@(posedge clk_in);
		rx_msg_done_in <= 1'b0;
		tx_all_aborted_in <= 1'b0;
		@(posedge clk_in);
	endtask : pulse

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	initial
	begin
		{avs_read_in, avs_write_in, bit_tick_in, tx_all_aborted_in, rx_msg_done_in} = 5'h00;
		{cpu_idle_in, tx_busy_in, rx_bit_in} = 3'h1;
		avs_address_in = 4'h0;
		avs_byteenable_in = 4'h3;
		avs_writedata_in = 32'h0;
		{n_mismatch, checks, cycles} = '0;
		sys_rst_in = 1'b1;
		cyc(6);
		sys_rst_in <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0480);
		chk(current_operating_state_out, 3'h4);
		chk(outs, 6'h00);
		chk({module_halt_out, abort_all_transmits_out, capture_event_out}, 3'h0);
		chk(register_view_select_out, 1'b0);
		foreach (ROWS[i])
		begin
			bus(1'b1, 4'h0, {21'h0, ROWS[i].code, 8'h00});
			ticks(IB + 1, 1'b1);
			cyc(3);
			chk(current_operating_state_out, ROWS[i].code);
			chk(outs, ROWS[i].outs);
			bus(1'b0, 4'h0, 32'h0);
			chk(rd, {21'h0, ROWS[i].code, ROWS[i].code, 5'h00});
		end
		// a dominant bit restarts the quiet count
		bus(1'b1, 4'h0, 32'h0);
		ticks(1, 1'b0);
		bus(1'b1, 4'h0, 32'h0000_0100);
		ticks(IB - 1, 1'b1);
		cyc(3);
		chk(current_operating_state_out, 3'h0);
		ticks(1, 1'b1);
		cyc(3);
		chk(current_operating_state_out, 3'h1);
		bus(1'b1, 4'h0, 32'h0000_0500);
		cyc(3);
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0520);
		bus(1'b1, 4'h0, 32'h0000_2109);
		cpu_idle_in <= 1'b1;
		cyc(3);
		chk(module_halt_out, 1'b1);
		chk(register_view_select_out, 1'b1);
		pulse(1'b1);
		chk(capture_event_out, 1'b1);
		avs_byteenable_in <= 4'h1;
		bus(1'b1, 4'h0, 32'h0);
		cpu_idle_in <= 1'b0;
		avs_byteenable_in <= 4'h3;
		pulse(1'b1);
		chk(capture_event_out, 1'b0);
		chk(register_view_select_out, 1'b0);
		chk(module_halt_out, 1'b0);
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_2120);
		bus(1'b1, 4'h0, 32'h0000_1100);
		cyc(2);
		chk(abort_all_transmits_out, 1'b1);
		pulse(1'b0);
		cyc(2);
		chk(abort_all_transmits_out, 1'b0);
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h0);
		// software set and hardware clear in one cycle: the set wins
		tx_all_aborted_in <= 1'b1;
		bus(1'b1, 4'h0, 32'h0000_1100);
		tx_all_aborted_in <= 1'b0;
		cyc(1);
		chk(abort_all_transmits_out, 1'b1);
		// configuration is refused while a frame is being sent
		tx_busy_in <= 1'b1;
		bus(1'b1, 4'h0, 32'h0000_0400);
		cyc(3);
		chk(current_operating_state_out, 3'h1);
		tx_busy_in <= 1'b0;
		cyc(3);
		chk(current_operating_state_out, 3'h4);
		// a second reset in mid-run restores the power-on view
		sys_rst_in <= 1'b1;
		cyc(2);
		sys_rst_in <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0480);
		chk(abort_all_transmits_out, 1'b0);
		conclude();
	end
endmodule : cmc_mode_ctrl_tb

// ### verilog/cmc_idle_detect.sv
`timescale 1ns/1ps

module cmc_idle_detect #(
	parameter int IDLE_BITS  = cmc_pkg::IDLE_BITS,
	parameter int CNT_W      = cmc_pkg::IDLE_CNT_W
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	// sampled bus bit
	input  wire logic bit_tick_in,
	input  wire logic rx_bit_in,
	// idle indication
	output logic      bus_idle_out
);

	localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(IDLE_BITS);
	localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);

	logic [CNT_W-1:0] recessive_cnt_reg;
	logic [CNT_W-1:0] recessive_cnt_next;
	logic             bus_idle_reg;
	wire              cnt_full;

	assign cnt_full = (recessive_cnt_reg >= CNT_LIMIT);

	// a dominant bit restarts the count; the count saturates once idle
	always_comb
	begin
		recessive_cnt_next = recessive_cnt_reg;
		if (bit_tick_in)
		begin
			if (!rx_bit_in)
				recessive_cnt_next = CNT_ZERO;
			else if (!cnt_full)
				recessive_cnt_next = recessive_cnt_reg + CNT_ONE;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			recessive_cnt_reg <= CNT_ZERO;
			bus_idle_reg      <= 1'b0;
		end
		else
		begin
			recessive_cnt_reg <= recessive_cnt_next;
			bus_idle_reg      <= (recessive_cnt_next >= CNT_LIMIT);
		end
	end

	assign bus_idle_out = bus_idle_reg;

endmodule : cmc_idle_detect

// ### verilog/cmc_mode_ctrl.sv
// What this block does
// - stop-in-idle set halts module during cpu idle
// - software sets abort-all, hardware clears when done
// - request codes 001 to 100 select disable..configuration
// - current-state field reports the state in effect
// - capture enable turns received messages into capture events
// - view select: one filters, zero buffers
// - state changes wait for eleven recessive bits, except changes out of disable or configuration, which happen at once
// - request 000 selects normal transmit and receive
// - request 111 selects listen-all, errors ignored
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps

module cmc_mode_ctrl #(
	parameter int IDLE_BITS = cmc_pkg::IDLE_BITS
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// protocol engine status
	input  wire logic        bit_tick_in,
	input  wire logic        rx_bit_in,
	input  wire logic        tx_busy_in,
	input  wire logic        tx_all_aborted_in,
	input  wire logic        rx_msg_done_in,
	// system status
	input  wire logic        cpu_idle_in,
	// engine controls
	output logic             module_halt_out,
	output logic             abort_all_transmits_out,
	output logic             capture_event_out,
	output logic             register_view_select_out,
	output logic      [2:0]  current_operating_state_out,
	output logic             tx_enable_out,
	output logic             rx_enable_out,
	output logic             send_ack_errors_out,
	output logic             loopback_out,
	output logic             listen_all_out,
	output logic             pins_to_can_out
);

	// true while the module is off the bus and may switch at once
	function automatic logic is_offline(input cmc_pkg::cmc_opmode_t m);
		is_offline = (m == cmc_pkg::OP_DISABLE) || (m == cmc_pkg::OP_CONFIG);
	endfunction : is_offline

	// reserved request codes are never adopted
	function automatic logic is_reserved(input cmc_pkg::cmc_opmode_t m);
		is_reserved = (m == cmc_pkg::OP_RSVD_5) || (m == cmc_pkg::OP_RSVD_6);
	endfunction : is_reserved

	// register state
	logic                 stop_in_cpu_idle_reg;
	logic                 abort_all_transmits_reg;
	cmc_pkg::cmc_opmode_t requested_operating_state_reg;
	cmc_pkg::cmc_opmode_t current_operating_state_reg;
	logic                 rx_timestamp_capture_enable_reg;
	logic                 register_view_select_reg;

	// bus slave state
	logic                 waitrequest_reg;
	logic [31:0]          readdata_reg;

	// registered outputs
	logic                 module_halt_reg;
	logic                 capture_event_reg;
	logic                 tx_enable_reg;
	logic                 rx_enable_reg;
	logic                 send_ack_errors_reg;
	logic                 loopback_reg;
	logic                 listen_all_reg;
	logic                 pins_to_can_reg;

	// next values
	logic                 stop_in_cpu_idle_next;
	logic                 abort_all_transmits_next;
	cmc_pkg::cmc_opmode_t requested_operating_state_next;
	cmc_pkg::cmc_opmode_t current_operating_state_next;
	logic                 rx_timestamp_capture_enable_next;
	logic                 register_view_select_next;

	// decode wires
	wire                  bus_idle;
	wire                  req_active;
	wire                  addr_hit;
	wire                  wr_commit;
	wire                  wr_lo;
	wire                  wr_hi;
	wire                  mode_pending;
	wire                  mode_accept;
	wire [15:0]           ctrl_one_view;
	wire [31:0]           read_value;
	wire [2:0]            wr_req_code;

	cmc_idle_detect #(
		.IDLE_BITS (IDLE_BITS),
		.CNT_W     (cmc_pkg::IDLE_CNT_W)
	) u_idle_detect (
		.clk_in       (clk_in),
		.sys_rst_in   (sys_rst_in),
		.bit_tick_in  (bit_tick_in),
		.rx_bit_in    (rx_bit_in),
		.bus_idle_out (bus_idle)
	);

	// one wait cycle, then a single low cycle at which the access completes
	assign req_active = avs_read_in || avs_write_in;
	assign addr_hit   = (avs_address_in == cmc_pkg::CTRL_ONE_ADDR);
	assign wr_commit  = avs_write_in && !waitrequest_reg && addr_hit;
	assign wr_lo      = wr_commit && avs_byteenable_in[0];
	assign wr_hi      = wr_commit && avs_byteenable_in[1];
	assign wr_req_code = avs_writedata_in[cmc_pkg::REQ_OP_LSB +: cmc_pkg::OP_W];

	// unimplemented and reserved bits read zero
	assign ctrl_one_view = {
		2'b00,
		stop_in_cpu_idle_reg,
		abort_all_transmits_reg,
		1'b0,
		requested_operating_state_reg,
		current_operating_state_reg,
		1'b0,
		rx_timestamp_capture_enable_reg,
		2'b00,
		register_view_select_reg
	};

	// unmapped addresses answer with zero so the master never hangs
	assign read_value = addr_hit ? {16'h0000, ctrl_one_view} : cmc_pkg::READ_ZERO;

	// entering configuration is refused while a frame is being sent
	assign mode_pending = (requested_operating_state_reg != current_operating_state_reg);
	assign mode_accept  = mode_pending
		&& !is_reserved(requested_operating_state_reg)
		&& (is_offline(current_operating_state_reg) || bus_idle)
		&& !((requested_operating_state_reg == cmc_pkg::OP_CONFIG) && tx_busy_in);

	always_comb
	begin
		stop_in_cpu_idle_next            = stop_in_cpu_idle_reg;
		requested_operating_state_next   = requested_operating_state_reg;
		rx_timestamp_capture_enable_next = rx_timestamp_capture_enable_reg;
		register_view_select_next        = register_view_select_reg;
		if (wr_hi)
		begin
			stop_in_cpu_idle_next          = avs_writedata_in[cmc_pkg::STOP_IDLE_BIT];
			requested_operating_state_next = cmc_pkg::cmc_opmode_t'(wr_req_code);
		end
		if (wr_lo)
		begin
			rx_timestamp_capture_enable_next = avs_writedata_in[cmc_pkg::CAPTURE_BIT];
			register_view_select_next        = avs_writedata_in[cmc_pkg::VIEW_SEL_BIT];
		end
	end

	// a software set in the same cycle as the hardware clear keeps the bit set
	always_comb
	begin
		abort_all_transmits_next = abort_all_transmits_reg;
		if (tx_all_aborted_in)
			abort_all_transmits_next = 1'b0;
		if (wr_hi && avs_writedata_in[cmc_pkg::ABORT_ALL_BIT])
			abort_all_transmits_next = 1'b1;
	end

	always_comb
	begin
		current_operating_state_next = current_operating_state_reg;
		if (mode_accept)
			current_operating_state_next = requested_operating_state_reg;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			stop_in_cpu_idle_reg            <= 1'b0;
			abort_all_transmits_reg         <= 1'b0;
			requested_operating_state_reg   <= cmc_pkg::OP_RESET;
			current_operating_state_reg     <= cmc_pkg::OP_RESET;
			rx_timestamp_capture_enable_reg <= 1'b0;
			register_view_select_reg        <= 1'b0;
		end
		else
		begin
			stop_in_cpu_idle_reg            <= stop_in_cpu_idle_next;
			abort_all_transmits_reg         <= abort_all_transmits_next;
			requested_operating_state_reg   <= requested_operating_state_next;
			current_operating_state_reg     <= current_operating_state_next;
			rx_timestamp_capture_enable_reg <= rx_timestamp_capture_enable_next;
			register_view_select_reg        <= register_view_select_next;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			waitrequest_reg <= 1'b1;
			readdata_reg    <= cmc_pkg::READ_ZERO;
		end
		else
		begin
			waitrequest_reg <= !(req_active && waitrequest_reg);
			if (req_active && waitrequest_reg)
				readdata_reg <= read_value;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			module_halt_reg   <= 1'b0;
			capture_event_reg <= 1'b0;
		end
		else
		begin
			module_halt_reg   <= stop_in_cpu_idle_reg && cpu_idle_in;
			capture_event_reg <= rx_timestamp_capture_enable_reg && rx_msg_done_in;
		end
	end

	// per-state pin and engine controls follow the state in effect
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_enable_reg       <= 1'b0;
			rx_enable_reg       <= 1'b0;
			send_ack_errors_reg <= 1'b0;
			loopback_reg        <= 1'b0;
			listen_all_reg      <= 1'b0;
			pins_to_can_reg     <= 1'b0;
		end
		else
		begin
			tx_enable_reg       <= 1'b0;
			rx_enable_reg       <= 1'b0;
			send_ack_errors_reg <= 1'b0;
			loopback_reg        <= 1'b0;
			listen_all_reg      <= 1'b0;
			pins_to_can_reg     <= 1'b0;
			unique case (current_operating_state_reg)
				cmc_pkg::OP_NORMAL:
				begin
					tx_enable_reg       <= 1'b1;
					rx_enable_reg       <= 1'b1;
					send_ack_errors_reg <= 1'b1;
					pins_to_can_reg     <= 1'b1;
				end
				cmc_pkg::OP_LOOPBACK:
				begin
					tx_enable_reg <= 1'b1;
					rx_enable_reg <= 1'b1;
					loopback_reg  <= 1'b1;
				end
				cmc_pkg::OP_LISTEN_ONLY:
				begin
					rx_enable_reg   <= 1'b1;
					pins_to_can_reg <= 1'b1;
				end
				cmc_pkg::OP_LISTEN_ALL:
				begin
					rx_enable_reg   <= 1'b1;
					listen_all_reg  <= 1'b1;
					pins_to_can_reg <= 1'b1;
				end
				// disable and configuration keep everything off the bus
				cmc_pkg::OP_DISABLE, cmc_pkg::OP_CONFIG:
				begin
					tx_enable_reg <= 1'b0;
				end
				// reserved codes cannot be adopted as the state in effect
				default:
				begin
					tx_enable_reg <= 1'b0;
				end
			endcase
		end
	end

	assign avs_readdata_out            = readdata_reg;
	assign avs_waitrequest_out         = waitrequest_reg;
	assign module_halt_out             = module_halt_reg;
	assign abort_all_transmits_out     = abort_all_transmits_reg;
	assign capture_event_out           = capture_event_reg;
	assign register_view_select_out    = register_view_select_reg;
	assign current_operating_state_out = current_operating_state_reg;
	assign tx_enable_out               = tx_enable_reg;
	assign rx_enable_out               = rx_enable_reg;
	assign send_ack_errors_out         = send_ack_errors_reg;
	assign loopback_out                = loopback_reg;
	assign listen_all_out              = listen_all_reg;
	assign pins_to_can_out             = pins_to_can_reg;

endmodule : cmc_mode_ctrl

// ### verilog/cmc_pkg.sv
package cmc_pkg;

	// register map, byte addresses on the avalon slave
	localparam logic [3:0]  CTRL_ONE_ADDR   = 4'h0;
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam int          REG_W           = 16;

	// field positions inside can_module_control_one
	localparam int          STOP_IDLE_BIT   = 13;
	localparam int          ABORT_ALL_BIT   = 12;
	localparam int          RESERVED_BIT    = 11;
	localparam int          REQ_OP_LSB      = 8;
	localparam int          CUR_OP_LSB      = 5;
	localparam int          CAPTURE_BIT     = 3;
	localparam int          VIEW_SEL_BIT    = 0;
	localparam int          OP_W            = 3;

	// reset value: both state fields at configuration, all else zero
	localparam logic [15:0] CTRL_ONE_RESET  = 16'h0480;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

	// bus idle needs this many consecutive recessive bits
	localparam int          IDLE_BITS       = 11;
	localparam int          IDLE_CNT_W      = 4;

	// operating states, codes follow declaration order 000..111
	typedef enum logic [2:0] {
		OP_NORMAL,
		OP_DISABLE,
		OP_LOOPBACK,
		OP_LISTEN_ONLY,
		OP_CONFIG,
		OP_RSVD_5,
		OP_RSVD_6,
		OP_LISTEN_ALL
	} cmc_opmode_t;

	localparam cmc_opmode_t OP_RESET        = OP_CONFIG;

endpackage : cmc_pkg
